// File: spc_cfg.svh
// constants of the servo position command path
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// clock and time base
`define SPC_CLK_MHZ      250
`define SPC_TICK_US      100
`define SPC_MS_US        1000
`define SPC_DEB_FAST_US  500
`define SPC_DEB_MID_US   1000
`define SPC_DEB_SLOW_US  2000
`define SPC_DEB_N_FAST   2'h2
`define SPC_DEB_N_SLOW   2'h3
// encoder and setting ranges
`define SPC_ENC_RES      32'h0002_0000
`define SPC_RANGE_MAX    32'h4000_0000
`define SPC_PPR_MIN      32'h0000_0010
`define SPC_FIR_MAX      16'h0500
`define SPC_FIR_DEPTH    128
`define SPC_RATIO_LO     64'h0000_0000_0098_9680
`define SPC_RATIO_HI_N   64'h0000_0000_0000_0005
`define SPC_RATIO_HI_D   64'h0000_0000_0000_0002
// register offsets
`define SPC_A_CTL        8'h00
`define SPC_A_UPR        8'h04
`define SPC_A_NUM1       8'h08
`define SPC_A_NUM2       8'h0C
`define SPC_A_NUM3       8'h10
`define SPC_A_NUM4       8'h14
`define SPC_A_DEN        8'h18
`define SPC_A_IIR        8'h1C
`define SPC_A_FIR        8'h20
`define SPC_A_PPR        8'h24
`define SPC_A_THR        8'h28
`define SPC_A_HOLD       8'h2C
`define SPC_A_DEV        8'h30
`define SPC_A_STAT       8'h34
`define SPC_A_CNT        8'h38
// control field positions
`define SPC_CTL_MODE     2:0
`define SPC_CTL_CLR      4:3
`define SPC_CTL_DEB      6:5
`define SPC_CTL_DIRCW    7
`define SPC_CTL_ZLOW     8
`define SPC_CTL_OSEL     9
// reset values
`define SPC_RST_CTL      10'h000
`define SPC_RST_GEAR     32'h0000_0001
`define SPC_RST_PPR      32'h0000_2710
`define SPC_RST_THR      32'h0064_000A
`define SPC_RST_HOLD     16'h0001
`endif

// File: spc_ctrl_model.sv
// upper controller model: command pulses and digital inputs
`timescale 1ns/1ps
module spc_ctrl_model (
  input  wire logic clk,
  output logic      cmd_step,
  output logic      cmd_dir,
  output logic      inhibit_in,
  output logic      deviation_clear_in
);
  // idle levels at time zero
  initial begin
    cmd_step           = 1'b0;
    cmd_dir            = 1'b1;
    inhibit_in         = 1'b0;
    deviation_clear_in = 1'b0;
  end
  // one-cycle pulses, gap of one cycle keeps the gear at 1 count/clock
  task automatic send(input int n, input logic dir);
    for (int i = 0; i < n; i++) begin
      @(posedge clk) cmd_step <= 1'b1;
      cmd_dir <= dir;
      @(posedge clk) cmd_step <= 1'b0;
    end
  endtask : send
  // inhibit comes from the seventh digital input only
  task automatic set_inhibit(input logic v);
    @(posedge clk) inhibit_in <= v;
  endtask : set_inhibit
  task automatic set_clear(input logic v);
    @(posedge clk) deviation_clear_in <= v;
  endtask : set_clear
endmodule : spc_ctrl_model

// File: spc_pkg.sv
// types of the servo position command path
package spc_pkg;
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } spc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } spc_apb_rsp_t;
  typedef enum logic [1:0] {
    SPC_DONE_ERR, SPC_DONE_CMD0, SPC_DONE_HOLD, SPC_DONE_FILT0
  } spc_done_t;
  typedef struct packed {
    logic [9:0]          ctl;
    logic [31:0]         upr;
    logic [3:0][31:0]    num;
    logic [31:0]         den;
    logic [15:0]         iir_tc;
    logic [31:0]         fir_t;
    logic [31:0]         ppr;
    logic [31:0]         thr;
    logic [15:0]         hold;
    logic [31:0]         prdata;
    logic                perr;
    logic [31:0]         tck;
    logic [3:0]          msc;
    logic signed [63:0]  gacc;
    logic signed [31:0]  cpos;
    logic [31:0]         icnt;
    logic signed [31:0]  iir;
    logic signed [31:0]  fprev;
    logic signed [31:0]  fsnap;
    logic signed [31:0]  dev;
    logic [4:0]          smp;
    logic [1:0]          same;
    logic                ilast;
    logic                inh;
    logic                gflt;
    logic                cseen;
    logic                czero;
    logic                fzero;
    logic [15:0]         hold_c;
    logic                done;
    logic                near;
    logic signed [63:0]  oacc;
    logic [31:0]         rpos;
    logic [1:0]          qd;
    logic                zo;
  } spc_st_t;
endpackage : spc_pkg

// File: spc_top.sv
// position command path: gear, filters, pulse output, completion
//
// Contract
// - units-per-rev setting 0..2^30; nonzero selects revolution scaling.
// - four numerators and one denominator, each 1..2^30.
// - with units setting 0, flag gear fault when ratio is outside res/1e7 .. res/2.5.
// - IIR smoothing of the scaled command, time 0..6553.5 ms.
// - two FIR smoothing stages, each 0.0..128.0 ms.
// - A/B quadrature position output plus one Z per revolution.
// - output pulses per revolution set from 16 to 2^30.
// - direction setting 0 makes CCW positive, 1 makes CW positive.
// - Z active high when polarity 0, active low when 1.
// - output source 0 divided encoder, 1 echo of command pulses.
// - deviation cleared per clear mode 0..3.
// - inhibit ignores command pulses and freezes the input counter.
// - inhibit level taken after 2 or 3 equal samples at 0.5/1/2 ms.
// - mode 0: done when absolute deviation below threshold.
// - mode 1: also requires incoming command zero.
// - mode 2: mode 1 condition, then done held for hold time.
// - mode 3: also requires filtered command zero.
// - modes 4..7 repeat 0..3 and need zero speed valid.
// - near output when deviation within near threshold.
// - units setting nonzero: res*in/units, else num*in/den.
// - two select inputs pick numerator 1..4.
`timescale 1ns/1ps
`include "spc_cfg.svh"
module spc_top #(
  parameter int TICK_CYC = `SPC_TICK_US * `SPC_CLK_MHZ
) (
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire spc_pkg::spc_apb_req_t apb_req,
  output spc_pkg::spc_apb_rsp_t     apb_rsp,
  input  wire logic                 cmd_step,
  input  wire logic                 cmd_dir,
  input  wire logic                 enc_step,
  input  wire logic                 enc_dir,
  input  wire logic                 servo_on,
  input  wire logic                 fault_in,
  input  wire logic                 zero_speed,
  input  wire logic                 deviation_clear_in,
  input  wire logic                 inhibit_in,
  input  wire logic                 ratio_pick_lo,
  input  wire logic                 ratio_pick_hi,
  output logic                      out_a,
  output logic                      out_b,
  output logic                      out_z,
  output logic                      position_done_out,
  output logic                      near_out,
  output logic                      gear_fault_out
);
  localparam int MS_TK = `SPC_MS_US / `SPC_TICK_US;
  localparam int DEB_F = `SPC_DEB_FAST_US / `SPC_TICK_US;
  localparam int DEB_M = `SPC_DEB_MID_US / `SPC_TICK_US;
  localparam int DEB_S = `SPC_DEB_SLOW_US / `SPC_TICK_US;

  spc_pkg::spc_st_t q;
  spc_pkg::spc_st_t d;
  logic               tick;
  logic               msp;
  logic               acc_in;
  logic [31:0]        num_sel;
  logic               gbad;
  logic               flt;
  logic               clr;
  logic signed [31:0] fpos;
  logic [31:0]        adev;
  logic               base;
  logic               cond;

  // index of the highest set bit, zero for zero
  function automatic logic [4:0] spc_log2(input logic [31:0] v);
    spc_log2 = 5'h00;
    for (int i = 0; i < 32; i++) begin
      if (v[i]) begin
        spc_log2 = 5'(i);
      end
    end
  endfunction : spc_log2

  // word address inside the register map
  function automatic logic spc_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= `SPC_A_CNT);
  endfunction : spc_mapped

  // inclusive range check of a written value
  function automatic logic spc_in(input logic [31:0] v,
                                 input logic [31:0] lo,
                                 input logic [31:0] hi);
    return (v >= lo) && (v <= hi);
  endfunction : spc_in

  // time base: 0.1 ms tick and 1 ms pulse
  assign tick = q.tck == 32'(TICK_CYC - 1);
  assign msp  = tick && (q.msc == 4'(MS_TK - 1));

  // accepted command pulse and gear selection
  assign acc_in  = cmd_step & ~q.inh;
  assign num_sel = q.num[{ratio_pick_hi, ratio_pick_lo}];
  assign gbad = (q.upr == 32'h0000_0000) && (
    ({32'h0, num_sel} * `SPC_RATIO_LO <
      {32'h0, `SPC_ENC_RES} * {32'h0, q.den}) ||
    ({32'h0, num_sel} * `SPC_RATIO_HI_N >
      {32'h0, `SPC_ENC_RES} * `SPC_RATIO_HI_D * {32'h0, q.den}));

  // deviation clear source per mode
  assign flt = fault_in | q.gflt;
  always_comb begin
    case (q.ctl[`SPC_CTL_CLR])
      2'h0:    clr = ~servo_on | flt;
      2'h1:    clr = flt;
      2'h2:    clr = ~servo_on | flt | deviation_clear_in;
      2'h3:    clr = deviation_clear_in;
      default: clr = flt;
    endcase
  end

  // two moving-average stages on the smoothed command
  logic signed [31:0] fir_x [0:2];
  assign fir_x[0] = q.iir;
  for (genvar g = 0; g < 2; g++) begin : g_fir
    logic signed [31:0]        ring [0:`SPC_FIR_DEPTH-1];
    logic [`SPC_FIR_DEPTH-1:0] fill_q;
    logic [6:0]                ptr_q;
    logic signed [38:0]        sum_q;
    logic [15:0]               t;
    logic [4:0]                k;
    logic [6:0]                tap;
    logic signed [31:0]        old;
    assign t   = (g == 0) ? q.fir_t[15:0] : q.fir_t[31:16];
    assign k   = spc_log2({16'h0, t / 16'(MS_TK)});
    assign tap = ptr_q - 7'(32'd1 << k);
    assign old = fill_q[tap] ? ring[tap] : 32'sh0000_0000;
    // window is a power of two samples at 1 ms
    always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
        fill_q <= '0;
        ptr_q  <= 7'h00;
        sum_q  <= 39'sh0;
      end else if (msp) begin
        fill_q[ptr_q] <= 1'b1;
        ptr_q         <= ptr_q + 7'h01;
        sum_q         <= sum_q + 39'(fir_x[g]) - 39'(old);
      end
    end
    always_ff @(posedge clk) begin
      if (msp) begin
        ring[ptr_q] <= fir_x[g];
      end
    end
    assign fir_x[g+1] = (t == 16'h0000) ? fir_x[g] : 32'(sum_q >>> k);
  end
  assign fpos = fir_x[2];

  // completion condition from deviation, command and speed
  assign adev = q.dev[31] ? 32'(-q.dev) : 32'(q.dev);
  assign base = adev < {16'h0, q.thr[15:0]};
  always_comb begin
    case (spc_pkg::spc_done_t'(q.ctl[1:0]))
      spc_pkg::SPC_DONE_ERR:   cond = base;
      spc_pkg::SPC_DONE_CMD0:  cond = base & q.czero;
      spc_pkg::SPC_DONE_HOLD:  cond = base & q.czero;
      spc_pkg::SPC_DONE_FILT0: cond = base & q.fzero;
      default:                 cond = base;
    endcase
    if (q.ctl[2] && !zero_speed) begin
      cond = 1'b0;
    end
  end

  // next state of the block, except the two FIR stages
  always_comb begin
    logic signed [63:0] ga;
    logic signed [63:0] gm;
    logic signed [63:0] gd;
    logic signed [63:0] oa;
    logic signed [63:0] res;
    logic [31:0]        rdv;
    logic [4:0]         per;
    logic [1:0]         sm;
    logic               stp;
    logic               up;
    logic               z;
    ga  = q.gacc;
    gm  = 64'sh0;
    gd  = 64'sh0;
    oa  = q.oacc;
    res = $signed({32'h0, `SPC_ENC_RES});
    rdv = 32'h0000_0000;
    per = 5'h00;
    sm  = q.same;
    stp = 1'b0;
    up  = 1'b0;
    z   = 1'b0;
    d   = q;
    // time base counters
    d.tck = tick ? 32'h0000_0000 : q.tck + 32'h0000_0001;
    if (msp) begin
      d.msc = 4'h0;
    end else if (tick) begin
      d.msc = q.msc + 4'h1;
    end
    // register read data, captured in the setup phase
    case (apb_req.paddr)
      `SPC_A_CTL:  rdv = {22'h0, q.ctl};
      `SPC_A_UPR:  rdv = q.upr;
      `SPC_A_NUM1: rdv = q.num[0];
      `SPC_A_NUM2: rdv = q.num[1];
      `SPC_A_NUM3: rdv = q.num[2];
      `SPC_A_NUM4: rdv = q.num[3];
      `SPC_A_DEN:  rdv = q.den;
      `SPC_A_IIR:  rdv = {16'h0, q.iir_tc};
      `SPC_A_FIR:  rdv = q.fir_t;
      `SPC_A_PPR:  rdv = q.ppr;
      `SPC_A_THR:  rdv = q.thr;
      `SPC_A_HOLD: rdv = {16'h0, q.hold};
      `SPC_A_DEV:  rdv = q.dev;
      `SPC_A_STAT: rdv = {28'h0, q.near, q.done, q.inh, q.gflt};
      `SPC_A_CNT:  rdv = q.icnt;
      default:     rdv = 32'h0000_0000;
    endcase
    if (apb_req.psel && !apb_req.penable) begin
      d.prdata = rdv;
      d.perr   = ~spc_mapped(apb_req.paddr);
    end
    // register writes in the access phase; out-of-range values ignored
    if (apb_req.psel && apb_req.penable && apb_req.pwrite) begin
      case (apb_req.paddr)
        `SPC_A_CTL: d.ctl = apb_req.pwdata[9:0];
        `SPC_A_UPR: begin
          if (apb_req.pwdata <= `SPC_RANGE_MAX) begin
            d.upr = apb_req.pwdata;
          end
        end
        `SPC_A_NUM1, `SPC_A_NUM2, `SPC_A_NUM3, `SPC_A_NUM4: begin
          if (spc_in(apb_req.pwdata, 32'h0000_0001, `SPC_RANGE_MAX)) begin
            d.num[2'(apb_req.paddr[4:2] - 3'h2)] = apb_req.pwdata;
          end
        end
        `SPC_A_DEN: begin
          if (spc_in(apb_req.pwdata, 32'h0000_0001, `SPC_RANGE_MAX)) begin
            d.den = apb_req.pwdata;
          end
        end
        `SPC_A_IIR: d.iir_tc = apb_req.pwdata[15:0];
        `SPC_A_FIR: begin
          if (apb_req.pwdata[15:0] <= `SPC_FIR_MAX &&
              apb_req.pwdata[31:16] <= `SPC_FIR_MAX) begin
            d.fir_t = apb_req.pwdata;
          end
        end
        `SPC_A_PPR: begin
          if (spc_in(apb_req.pwdata, `SPC_PPR_MIN, `SPC_RANGE_MAX)) begin
            d.ppr = apb_req.pwdata;
          end
        end
        `SPC_A_THR: begin
          if (apb_req.pwdata[15:0] != 16'h0000 &&
              apb_req.pwdata[31:16] != 16'h0000) begin
            d.thr = apb_req.pwdata;
          end
        end
        `SPC_A_HOLD: begin
          if (apb_req.pwdata[15:0] != 16'h0000) begin
            d.hold = apb_req.pwdata[15:0];
          end
        end
        default: d.ctl = q.ctl;
      endcase
    end
    // input counter frozen by inhibit
    if (acc_in) begin
      d.icnt = cmd_dir ? q.icnt + 32'h0000_0001
                       : q.icnt - 32'h0000_0001;
    end
    // electronic gear with carried remainder
    gm = (q.upr != 32'h0000_0000) ? res : $signed({32'h0, num_sel});
    gd = $signed({32'h0, (q.upr != 32'h0000_0000) ? q.upr : q.den});
    if (acc_in) begin
      ga = cmd_dir ? ga + gm : ga - gm;
    end
    if (ga >= gd) begin
      ga     = ga - gd;
      d.cpos = q.cpos + 32'sh0000_0001;
    end else if (ga <= -gd) begin
      ga     = ga + gd;
      d.cpos = q.cpos - 32'sh0000_0001;
    end
    d.gacc = ga;
    d.gflt = gbad;
    // low-pass smoothing, shift set by time constant
    if (q.iir_tc == 16'h0000) begin
      d.iir = q.cpos;
    end else if (tick) begin
      d.iir = q.iir + ((q.cpos - q.iir) >>>
                       spc_log2({16'h0, q.iir_tc}));
    end
    // inhibit input debounce
    case (q.ctl[`SPC_CTL_DEB])
      2'h0:    per = 5'(DEB_F);
      2'h1:    per = 5'(DEB_F);
      2'h2:    per = 5'(DEB_M);
      default: per = 5'(DEB_S);
    endcase
    if (tick) begin
      if (q.smp >= per - 5'h01) begin
        d.smp   = 5'h00;
        sm      = (inhibit_in == q.ilast) ?
                  ((q.same == 2'h3) ? 2'h3 : q.same + 2'h1) : 2'h1;
        d.same  = sm;
        d.ilast = inhibit_in;
        if (sm >= ((q.ctl[`SPC_CTL_DEB] == 2'h0) ? `SPC_DEB_N_FAST
                                                 : `SPC_DEB_N_SLOW)) begin
          d.inh = inhibit_in;
        end
      end else begin
        d.smp = q.smp + 5'h01;
      end
    end
    // deviation counter
    if (clr) begin
      d.dev = 32'sh0000_0000;
    end else begin
      d.dev = q.dev + (fpos - q.fprev) -
              (enc_step ? (enc_dir ? 32'sh0000_0001 : -32'sh0000_0001)
                        : 32'sh0000_0000);
    end
    d.fprev = fpos;
    // zero-command detection per tick; a pulse on the tick still counts
    d.cseen = (tick ? 1'b0 : q.cseen) | acc_in;
    if (tick) begin
      d.czero = ~(q.cseen | acc_in);
      d.fzero = fpos == q.fsnap;
      d.fsnap = fpos;
    end
    // completion with hold, near flag
    if (cond) begin
      d.hold_c = q.hold;
    end else if (msp && q.hold_c != 16'h0000) begin
      d.hold_c = q.hold_c - 16'h0001;
    end
    d.done = cond || ((q.ctl[1:0] == 2'h2) && q.hold_c != 16'h0000);
    d.near = adev <= {16'h0, q.thr[31:16]};
    // pulse output source and divider
    if (q.ctl[`SPC_CTL_OSEL]) begin
      stp = acc_in;
      up  = cmd_dir;
    end else begin
      if (enc_step) begin
        oa = enc_dir ? oa + $signed({30'h0, q.ppr, 2'h0})
                     : oa - $signed({30'h0, q.ppr, 2'h0});
      end
      if (oa >= res) begin
        oa  = oa - res;
        stp = 1'b1;
        up  = 1'b1;
      end else if (oa <= -res) begin
        oa  = oa + res;
        stp = 1'b1;
      end
    end
    d.oacc = oa;
    if (stp) begin
      d.qd = (up ^ q.ctl[`SPC_CTL_DIRCW]) ? q.qd + 2'h1
                                          : q.qd - 2'h1;
    end
    // revolution position for the index
    if (enc_step) begin
      if (enc_dir) begin
        z      = q.rpos == `SPC_ENC_RES - 32'h0000_0001;
        d.rpos = z ? 32'h0000_0000 : q.rpos + 32'h0000_0001;
      end else begin
        z      = q.rpos == 32'h0000_0000;
        d.rpos = z ? `SPC_ENC_RES - 32'h0000_0001
                   : q.rpos - 32'h0000_0001;
      end
    end
    d.zo = z ^ q.ctl[`SPC_CTL_ZLOW];
  end

  // state register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      q        <= '0;
      q.ctl    <= `SPC_RST_CTL;
      q.num    <= {4{`SPC_RST_GEAR}};
      q.den    <= `SPC_RST_GEAR;
      q.ppr    <= `SPC_RST_PPR;
      q.thr    <= `SPC_RST_THR;
      q.hold   <= `SPC_RST_HOLD;
      q.czero  <= 1'b1;
      q.fzero  <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs
  assign apb_rsp.prdata  = q.prdata;
  assign apb_rsp.pready  = 1'b1;
  assign apb_rsp.pslverr = q.perr & apb_req.psel & apb_req.penable;
  assign out_a             = q.qd[1];
  assign out_b             = q.qd[1] ^ q.qd[0];
  assign out_z             = q.zo;
  assign position_done_out = q.done;
  assign near_out          = q.near;
  assign gear_fault_out    = q.gflt;

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence s_hold_go;
    q.ctl[1:0] == 2'h2 && cond;
  endsequence
  sequence s_done_two;
    position_done_out [*2];
  endsequence

  a_gear_fault_set: assert property (gbad |=> gear_fault_out)
    else $error("gear fault not raised");
  a_inhibit_freeze: assert property (q.inh |=> $stable(q.icnt))
    else $error("input counter moved while inhibited");
  a_dev_clear_now: assert property (clr |=> q.dev == 32'sh0)
    else $error("deviation not cleared");
  a_done_err_mode: assert property (
    q.ctl[2:0] == 3'h0 && base |=> position_done_out)
    else $error("done missing in mode 0");
  a_done_zero_spd: assert property (
    q.ctl[2] && q.ctl[1:0] != 2'h2 && !zero_speed
    |=> !position_done_out)
    else $error("done without zero speed");
  a_hold_keeps_done: assert property (s_hold_go |=> s_done_two)
    else $error("done not held");
  a_near_window: assert property (
    adev <= {16'h0, q.thr[31:16]} |=> near_out)
    else $error("near missing");
  a_quad_one_edge: assert property (
    $countones({out_a, out_b} ^ {$past(out_a), $past(out_b)}) <= 1)
    else $error("quadrature broken");
  a_z_idle_level: assert property (
    !enc_step |=> out_z == $past(q.ctl[`SPC_CTL_ZLOW]))
    else $error("index idle level wrong");
endmodule : spc_top

// File: spc_top_tb.sv
// self-checking bench of the position command path
`timescale 1ns/1ps
`include "spc_cfg.svh"
module spc_top_tb;
  logic                  clk = 1'b0;
  logic                  nrst = 1'b0;
  spc_pkg::spc_apb_req_t apb_req = '0;
  spc_pkg::spc_apb_rsp_t apb_rsp;
  logic cmd_step, cmd_dir, inhibit_in, deviation_clear_in;
  logic enc_step = 1'b0, enc_dir = 1'b1, servo_on = 1'b1;
  logic fault_in = 1'b0, zero_speed = 1'b1, pick_lo = 1'b0, pick_hi = 1'b0;
  logic out_a, out_b, out_z, done, near, gfault;
  logic [1:0]  ab_q = 2'b00;
  int          edges = 0, cyc = 0, n_errors = 0, n_tests = 0;
  int          e0 = 0, zc = 0;
  logic [31:0] rd;
  logic        er;
  // 250 MHz clock
  always #2 clk = ~clk;
  spc_top #(.TICK_CYC(4)) spc_top_inst (
    .clk(clk), .nrst(nrst), .apb_req(apb_req), .apb_rsp(apb_rsp),
    .cmd_step(cmd_step), .cmd_dir(cmd_dir), .enc_step(enc_step),
    .enc_dir(enc_dir), .servo_on(servo_on), .fault_in(fault_in),
    .zero_speed(zero_speed), .deviation_clear_in(deviation_clear_in),
    .inhibit_in(inhibit_in), .ratio_pick_lo(pick_lo),
    .ratio_pick_hi(pick_hi), .out_a(out_a), .out_b(out_b), .out_z(out_z),
    .position_done_out(done), .near_out(near), .gear_fault_out(gfault));
  spc_ctrl_model spc_ctrl_model_inst (
    .clk(clk), .cmd_step(cmd_step), .cmd_dir(cmd_dir),
    .inhibit_in(inhibit_in), .deviation_clear_in(deviation_clear_in));
  // quadrature edge counter and hang guard
  always @(posedge clk) begin
    ab_q <= {out_a, out_b};
    if ({out_a, out_b} !== ab_q) edges <= edges + 1;
    if (out_z === 1'b0) zc <= zc + 1;
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      n_errors++;
      finish_test();
    end
  end
  task automatic finish_test();
    if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] e, got);
    n_tests++;
    if (got !== e) begin
      $display("Error %s expected %h seen %h", nm, e, got);
      n_errors++;
    end
  endtask : chk
  // one apb transfer: setup, access until pready, release
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge clk) apb_req <= '{1'b1, 1'b0, w, a, d};
    @(posedge clk) apb_req.penable <= 1'b1;
    @(posedge clk);
    while (apb_rsp.pready !== 1'b1) @(posedge clk);
    rd = apb_rsp.prdata;
    er = apb_rsp.pslverr;
    apb_req <= '0;
  endtask : xfer
  task automatic rchk(input string nm, input logic [7:0] a,
                      input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    chk(nm, e, rd);
  endtask : rchk
  task automatic enc(input int n);
    repeat (n) begin
      @(posedge clk) enc_step <= 1'b1;
      @(posedge clk) enc_step <= 1'b0;
    end
  endtask : enc
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  // main sequence
  initial begin
    idle(5);
    nrst <= 1'b1;
    idle(2);
    rchk("ctl", `SPC_A_CTL, 32'h0000_0000);
    rchk("num1", `SPC_A_NUM1, `SPC_RST_GEAR);
    rchk("den", `SPC_A_DEN, `SPC_RST_GEAR);
    rchk("ppr", `SPC_A_PPR, `SPC_RST_PPR);
    rchk("thr", `SPC_A_THR, `SPC_RST_THR);
    rchk("hold", `SPC_A_HOLD, 32'h0000_0001);
    xfer(1'b1, `SPC_A_NUM1, 32'h0000_0000);
    rchk("num1 zero", `SPC_A_NUM1, 32'h0000_0001);
    xfer(1'b1, `SPC_A_NUM1, 32'h4000_0001);
    rchk("num1 big", `SPC_A_NUM1, 32'h0000_0001);
    xfer(1'b1, `SPC_A_PPR, 32'h0000_000F);
    rchk("ppr low", `SPC_A_PPR, `SPC_RST_PPR);
    xfer(1'b1, `SPC_A_UPR, 32'h4000_0000);
    rchk("upr max", `SPC_A_UPR, 32'h4000_0000);
    xfer(1'b1, `SPC_A_UPR, 32'h0000_0000);
    xfer(1'b0, 8'h3C, 32'h0000_0000);
    chk("unmapped", 32'h0000_0001, {31'h0, er});
    chk("unmapped rd", 32'h0000_0000, rd);
    // gear ratio fault and numerator selection
    xfer(1'b1, `SPC_A_NUM2, 32'h0001_0000);
    idle(3);
    chk("fault n1", 32'h0, {31'h0, gfault});
    pick_lo <= 1'b1;
    idle(3);
    chk("fault n2", 32'h1, {31'h0, gfault});
    pick_lo <= 1'b0;
    xfer(1'b1, `SPC_A_DEN, 32'h0000_0064);
    idle(3);
    chk("fault low", 32'h1, {31'h0, gfault});
    xfer(1'b1, `SPC_A_DEN, 32'h0000_0001);
    idle(3);
    chk("fault off", 32'h0, {31'h0, gfault});
    // command pulses, deviation, completion and near
    spc_ctrl_model_inst.send(20, 1'b1);
    idle(10);
    rchk("cnt", `SPC_A_CNT, 32'd20);
    rchk("dev", `SPC_A_DEV, 32'd20);
    chk("done far", 32'h0, {31'h0, done});
    chk("near", 32'h1, {31'h0, near});
    enc(20);
    idle(5);
    rchk("dev zero", `SPC_A_DEV, 32'd0);
    chk("done", 32'h1, {31'h0, done});
    // inhibit after debounce freezes the counter
    spc_ctrl_model_inst.set_inhibit(1'b1);
    idle(100);
    spc_ctrl_model_inst.send(5, 1'b1);
    idle(5);
    rchk("cnt inh", `SPC_A_CNT, 32'd20);
    rchk("stat inh", `SPC_A_STAT, 32'h0000_000E);
    spc_ctrl_model_inst.set_inhibit(1'b0);
    idle(100);
    // clear input in mode 3, servo off in mode 0
    xfer(1'b1, `SPC_A_CTL, 32'h0000_0018);
    spc_ctrl_model_inst.send(7, 1'b1);
    idle(10);
    rchk("dev7", `SPC_A_DEV, 32'd7);
    spc_ctrl_model_inst.set_clear(1'b1);
    spc_ctrl_model_inst.set_clear(1'b0);
    idle(5);
    rchk("dev clr", `SPC_A_DEV, 32'd0);
    xfer(1'b1, `SPC_A_CTL, 32'h0000_0000);
    spc_ctrl_model_inst.send(4, 1'b1);
    idle(10);
    servo_on <= 1'b0;
    idle(5);
    rchk("dev off", `SPC_A_DEV, 32'd0);
    servo_on <= 1'b1;
    // done mode 4 waits for zero speed, mode 2 holds done
    xfer(1'b1, `SPC_A_CTL, 32'h0000_0004);
    zero_speed <= 1'b0;
    idle(3);
    chk("done nzs", 32'h0, {31'h0, done});
    zero_speed <= 1'b1;
    idle(3);
    chk("done zs", 32'h1, {31'h0, done});
    xfer(1'b1, `SPC_A_HOLD, 32'h0000_0005);
    xfer(1'b1, `SPC_A_CTL, 32'h0000_0002);
    idle(20);
    chk("done m2", 32'h1, {31'h0, done});
    spc_ctrl_model_inst.send(12, 1'b1);
    idle(2);
    chk("done held", 32'h1, {31'h0, done});
    idle(250);
    chk("done drop", 32'h0, {31'h0, done});
    // echo of command pulses on the quadrature output
    xfer(1'b1, `SPC_A_CTL, 32'h0000_0200);
    idle(3);
    e0 = edges;
    spc_ctrl_model_inst.send(8, 1'b1);
    idle(5);
    chk("echo edges", 32'd8, edges - e0);
    // active-low index when the revolution count wraps downwards
    xfer(1'b1, `SPC_A_CTL, 32'h0000_0100);
    idle(2);
    chk("z idle", 32'h1, {31'h0, out_z});
    e0 = zc;
    enc_dir <= 1'b0;
    enc(21);
    idle(3);
    chk("z pulse", 32'd1, zc - e0);
    finish_test();
  end
endmodule : spc_top_tb
